// [shared/pdt_pkg.sv]
// Constants shared by the panel video source controller
package pdt_pkg;
    // ----------------------------------------
    // Line and frame timing in link clocks and lines, pixel format and counter width
    // ----------------------------------------
    localparam int unsigned LINE_ACTIVE_CLOCKS   = 480;
    localparam int unsigned LINE_BLANK_MIN       = 40;
    localparam int unsigned LINE_BLANK_TYP       = 70;
    localparam int unsigned LINE_BLANK_MAX       = 200;
    localparam int unsigned FRAME_ACTIVE_LINES   = 1080;
    localparam int unsigned FRAME_BLANK_MIN      = 20;
    localparam int unsigned FRAME_BLANK_TYP      = 45;
    localparam int unsigned FRAME_BLANK_MAX      = 86;
    localparam int unsigned FRAME_BLANK_LO_MIN   = 228;
    localparam int unsigned FRAME_BLANK_LO_TYP   = 270;
    localparam int unsigned FRAME_BLANK_LO_MAX   = 300;
    localparam int unsigned SSC_EXTRA_CLOCKS     = 2;
    localparam int unsigned PIXELS_PER_CLOCK     = 4;
    localparam int unsigned COLOUR_BITS          = 10;
    localparam int unsigned COLOUR_MAX           = 1023;
    localparam int unsigned CNT_W                = 12;
    // ----------------------------------------
    // Power sequence, times in ms and derived 10 MHz cycle counts
    // ----------------------------------------
    localparam int unsigned REF_CLK_HZ           = 10_000_000;
    localparam int unsigned SUPPLY_TO_SIGNAL_MS  = 200;
    localparam int unsigned SIGNAL_TO_OFF_MS     = 200;
    localparam int unsigned OFF_TO_ON_MS         = 1000;
    localparam int unsigned SIGNAL_TO_LIGHT_MS   = 100;
    localparam longint unsigned CYC_PER_MS       = REF_CLK_HZ / 1000;
    localparam int unsigned SUPPLY_TO_SIGNAL_CYC = int'(SUPPLY_TO_SIGNAL_MS * CYC_PER_MS);
    localparam int unsigned SIGNAL_TO_OFF_CYC    = int'(SIGNAL_TO_OFF_MS * CYC_PER_MS);
    localparam int unsigned OFF_TO_ON_CYC        = int'(OFF_TO_ON_MS * CYC_PER_MS);
    localparam int unsigned SIGNAL_TO_LIGHT_CYC  = int'(SIGNAL_TO_LIGHT_MS * CYC_PER_MS);
    localparam int unsigned TMR_W                = 24;
    // ----------------------------------------
    // Power sequencer states
    // ----------------------------------------
    typedef enum logic [6:0] {
        PDT_OFF      = 7'h01,
        PDT_SUP_ON   = 7'h02,
        PDT_SIG_ON   = 7'h04,
        PDT_LIT      = 7'h08,
        PDT_DARK     = 7'h10,
        PDT_SIG_OFF  = 7'h20,
        PDT_DISCHG   = 7'h40
    } pdt_pwr_state_t;
endpackage : pdt_pkg

// [core/pdt_sync.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module pdt_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : pdt_sync

// [core/pdt_pix_enc.sv]
// Pixel word packer for four pixels per link clock
`timescale 1ns/1ns
module pdt_pix_enc #(
    parameter int unsigned CB = 10
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              valid_in,
    input  wire logic              wide_in,
    input  wire logic [4*3*CB-1:0] pix_in,
    output logic      [4*3*CB-1:0] pix_out
);
    // Eight-bit mode zeroes the two LSBs carried on the fifth pair, keeping it quiet
    function automatic logic [CB-1:0] trim(input logic [CB-1:0] c, input logic w);
        trim = w ? c : {c[CB-1:2], 2'h0};
    endfunction : trim

    logic [4*3*CB-1:0] pix_d;
    always_comb
    begin
        pix_d = '0;
        for (int i = 0; i < 12; i++)
            pix_d[i*CB +: CB] = valid_in ? trim(pix_in[i*CB +: CB], wide_in) : '0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pix_out <= '0;
        else
            pix_out <= pix_d;
    end
endmodule : pdt_pix_enc

// [core/pdt_source.sv]
// Video source controller: power sequencing on ref clock, DE-only raster on link clock
// Behaviour
// - Each line: 480 active clocks then 40 to 200 blank clocks.
// - Each frame: 1080 active lines then 20 to 86 blank lines.
// - Lower-rate family uses 228 to 300 blank lines.
// - Link clock 66.97 to 78 MHz; counts chosen from actual clock (here taken from the blank count inputs, then clamped).
// - Spread-spectrum clock adds extra blank clocks above minimum.
// - Colours are 10-bit unsigned, MSB first, 0 to 1023.
// - No link signal before panel logic supply is on.
// - Supply stays off at least 1.0 s before switching on again.
// - Supply-to-signal and signal-to-off intervals at least 200 ms.
// - Signal-to-backlight interval at least 100 ms.
// - Link lines are always driven to a defined level.
// - With supply off, all data lines are driven low.
// - Mapping select is passed through to the panel; pixels are not re-encoded for it.
// - Fifth pair carries extra 10-bit bits, idle in 8-bit mode.
`timescale 1ns/1ns
module pdt_source #(
    parameter int unsigned SUP_TO_SIG_CYC = pdt_pkg::SUPPLY_TO_SIGNAL_CYC,
    parameter int unsigned SIG_TO_OFF_CYC = pdt_pkg::SIGNAL_TO_OFF_CYC,
    parameter int unsigned OFF_TO_ON_CYC  = pdt_pkg::OFF_TO_ON_CYC,
    parameter int unsigned SIG_TO_LIT_CYC = pdt_pkg::SIGNAL_TO_LIGHT_CYC
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       link_clk_in,
    input  wire logic                       power_req_in,
    input  wire logic                       low_rate_in,
    input  wire logic                       ssc_in,
    input  wire logic                       wide_colour_in,
    input  wire logic                       alt_bit_mapping_in,
    input  wire logic                       test_pattern_in,
    input  wire logic [pdt_pkg::CNT_W-1:0]  line_blank_clocks_in,
    input  wire logic [pdt_pkg::CNT_W-1:0]  frame_blank_lines_in,
    input  wire logic [119:0]               pix_in,
    output logic                            pix_req_out,
    output logic                            panel_logic_supply_out,
    output logic                            backlight_on_out,
    output logic                            alt_bit_mapping_out,
    output logic                            internal_test_pattern_out,
    output logic                            data_valid_strobe_out,
    output logic                            hsync_out,
    output logic                            vsync_out,
    output logic [119:0]                    pix_out,
    output logic                            ready_out
);
    // ----------------------------------------
    // Power sequencer, ref clock domain
    // ----------------------------------------
    pdt_pkg::pdt_pwr_state_t st_q;
    pdt_pkg::pdt_pwr_state_t st_d;
    logic [pdt_pkg::TMR_W-1:0] tmr_q;
    logic                      tmr_done;
    logic                      sig_en_q;

    always_comb
    begin
        case (st_q)
            // Full count: the output flop that leaves the state adds no extra cycle
            pdt_pkg::PDT_SUP_ON:  tmr_done = (tmr_q >= pdt_pkg::TMR_W'(SUP_TO_SIG_CYC));
            pdt_pkg::PDT_SIG_ON:  tmr_done = (tmr_q >= pdt_pkg::TMR_W'(SIG_TO_LIT_CYC));
            pdt_pkg::PDT_SIG_OFF: tmr_done = (tmr_q >= pdt_pkg::TMR_W'(SIG_TO_OFF_CYC));
            pdt_pkg::PDT_DISCHG:  tmr_done = (tmr_q >= pdt_pkg::TMR_W'(OFF_TO_ON_CYC));
            default:              tmr_done = 1'b1;
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            pdt_pkg::PDT_OFF:     if (power_req_in) st_d = pdt_pkg::PDT_SUP_ON;
            pdt_pkg::PDT_SUP_ON:  if (tmr_done) st_d = pdt_pkg::PDT_SIG_ON;
            pdt_pkg::PDT_SIG_ON:  if (!power_req_in) st_d = pdt_pkg::PDT_SIG_OFF;
                                  else if (tmr_done) st_d = pdt_pkg::PDT_LIT;
            pdt_pkg::PDT_LIT:     if (!power_req_in) st_d = pdt_pkg::PDT_DARK;
            pdt_pkg::PDT_DARK:    st_d = pdt_pkg::PDT_SIG_OFF;
            pdt_pkg::PDT_SIG_OFF: if (tmr_done) st_d = pdt_pkg::PDT_DISCHG;
            pdt_pkg::PDT_DISCHG:  if (tmr_done) st_d = pdt_pkg::PDT_OFF;
            default:              st_d = pdt_pkg::PDT_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st_q <= pdt_pkg::PDT_OFF;
        else
            st_q <= st_d;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tmr_q <= '0;
        else if (st_d != st_q)
            tmr_q <= '0;
        else if (!tmr_done)
            tmr_q <= tmr_q + 1'b1;
    end

    // Outputs come straight from flops decoded off the next state
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            panel_logic_supply_out <= 1'b0;
            backlight_on_out       <= 1'b0;
            sig_en_q               <= 1'b0;
            ready_out              <= 1'b0;
        end
        else
        begin
            panel_logic_supply_out <= (st_d != pdt_pkg::PDT_OFF) && (st_d != pdt_pkg::PDT_DISCHG);
            backlight_on_out       <= (st_d == pdt_pkg::PDT_LIT);
            sig_en_q               <= (st_d == pdt_pkg::PDT_SIG_ON) || (st_d == pdt_pkg::PDT_LIT)
                                      || (st_d == pdt_pkg::PDT_DARK);
            ready_out              <= (st_d == pdt_pkg::PDT_LIT);
        end
    end

    // ----------------------------------------
    // Crossing into the link domain
    // ----------------------------------------
    logic [5:0] cfg_s;
    logic       sig_en_s;
    logic       low_rate_s;
    logic       ssc_s;
    logic       wide_s;
    logic       map_s;
    logic       pat_s;
    pdt_sync #(.W(6)) u_sync_cfg (
        .clk_in   (link_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({sig_en_q, low_rate_in, ssc_in, wide_colour_in,
                    alt_bit_mapping_in, test_pattern_in}),
        .q_out    (cfg_s)
    );
    assign {sig_en_s, low_rate_s, ssc_s, wide_s, map_s, pat_s} = cfg_s;

    // Blank counts are quasi-static; they are only sampled while the link is held idle
    logic [pdt_pkg::CNT_W-1:0] hb_q;
    logic [pdt_pkg::CNT_W-1:0] vb_q;
    function automatic logic [pdt_pkg::CNT_W-1:0] clampv(input logic [pdt_pkg::CNT_W-1:0] v,
                                                          input int unsigned lo,
                                                          input int unsigned hi);
        if (v < pdt_pkg::CNT_W'(lo))
            clampv = pdt_pkg::CNT_W'(lo);
        else if (v > pdt_pkg::CNT_W'(hi))
            clampv = pdt_pkg::CNT_W'(hi);
        else
            clampv = v;
    endfunction : clampv

    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hb_q <= pdt_pkg::CNT_W'(pdt_pkg::LINE_BLANK_TYP);
            vb_q <= pdt_pkg::CNT_W'(pdt_pkg::FRAME_BLANK_TYP);
        end
        else if (!sig_en_s)
        begin
            hb_q <= clampv(line_blank_clocks_in, ssc_s ?
                           pdt_pkg::LINE_BLANK_MIN + pdt_pkg::SSC_EXTRA_CLOCKS :
                           pdt_pkg::LINE_BLANK_MIN, pdt_pkg::LINE_BLANK_MAX);
            vb_q <= low_rate_s ?
                    clampv(frame_blank_lines_in, pdt_pkg::FRAME_BLANK_LO_MIN,
                           pdt_pkg::FRAME_BLANK_LO_MAX) :
                    clampv(frame_blank_lines_in, pdt_pkg::FRAME_BLANK_MIN,
                           pdt_pkg::FRAME_BLANK_MAX);
        end
    end

    // ----------------------------------------
    // Raster counters, link domain
    // ----------------------------------------
    logic [pdt_pkg::CNT_W-1:0] hcnt_q;
    logic [pdt_pkg::CNT_W-1:0] vcnt_q;
    logic                      line_end;
    logic                      h_act;
    logic                      v_act;
    logic                      de_d;
    logic                      run;

    // The active part of a line already started is finished, so a power-down never cuts a strobe run
    assign run      = sig_en_s || (h_act && (hcnt_q != '0));
    assign line_end = (hcnt_q == pdt_pkg::CNT_W'(pdt_pkg::LINE_ACTIVE_CLOCKS) + hb_q - 1'b1);
    assign h_act    = (hcnt_q < pdt_pkg::CNT_W'(pdt_pkg::LINE_ACTIVE_CLOCKS));
    assign v_act    = (vcnt_q < pdt_pkg::CNT_W'(pdt_pkg::FRAME_ACTIVE_LINES));
    assign de_d     = run && h_act && v_act;

    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            hcnt_q <= '0;
        else if (!run || line_end)
            hcnt_q <= '0;
        else
            hcnt_q <= hcnt_q + 1'b1;
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            vcnt_q <= '0;
        else if (!run)
            vcnt_q <= '0;
        else if (line_end)
        begin
            if (vcnt_q == pdt_pkg::CNT_W'(pdt_pkg::FRAME_ACTIVE_LINES) + vb_q - 1'b1)
                vcnt_q <= '0;
            else
                vcnt_q <= vcnt_q + 1'b1;
        end
    end

    // Syncs are driven for completeness; the panel frames from the strobe alone
    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_valid_strobe_out <= 1'b0;
            hsync_out             <= 1'b0;
            vsync_out             <= 1'b0;
            pix_req_out           <= 1'b0;
        end
        else
        begin
            data_valid_strobe_out <= de_d;
            hsync_out             <= run && line_end;
            vsync_out             <= run && (vcnt_q == pdt_pkg::CNT_W'(pdt_pkg::FRAME_ACTIVE_LINES));
            pix_req_out           <= de_d;
        end
    end

    // Static selects are only released with the link, low meanwhile
    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            alt_bit_mapping_out       <= 1'b0;
            internal_test_pattern_out <= 1'b0;
        end
        else
        begin
            alt_bit_mapping_out       <= sig_en_s && map_s;
            internal_test_pattern_out <= sig_en_s && pat_s;
        end
    end

    // Pixel data zero outside active clocks and whenever the supply is off
    pdt_pix_enc #(.CB(pdt_pkg::COLOUR_BITS)) u_enc (
        .clk_in   (link_clk_in),
        .rst_n_in (rst_n_in),
        .valid_in (de_d),
        .wide_in  (wide_s),
        .pix_in   (pix_in),
        .pix_out  (pix_out)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    int unsigned de_run_q;
    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            de_run_q <= 0;
        else if (data_valid_strobe_out)
            de_run_q <= de_run_q + 1;
        else
            de_run_q <= 0;
    end

    a_de_run_len: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        $fell(data_valid_strobe_out) |-> de_run_q == 480)
        else $error("active run not 480 clocks");

    a_de_run_max: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        de_run_q <= 480)
        else $error("active run too long");

    a_blank_min: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        $fell(data_valid_strobe_out) |-> !data_valid_strobe_out [*8])
        else $error("line blank too short");

    a_pix_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        !$past(de_d) |-> pix_out == '0)
        else $error("pixel data not low in blank");

    sequence s_sup_up;
        $rose(panel_logic_supply_out);
    endsequence
    a_sup_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_sup_up |-> !sig_en_q [*8])
        else $error("signals before supply");

    a_sig_no_sup: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sig_en_q |-> panel_logic_supply_out)
        else $error("signals without supply");

    a_light_needs: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(backlight_on_out) |-> $past(sig_en_q))
        else $error("backlight before signals");

    a_offtime_min: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(panel_logic_supply_out) |-> !panel_logic_supply_out [*8])
        else $error("supply restarted too soon");
endmodule : pdt_source

// [tb/pdt_panel_model.sv]
// Behavioural panel model that frames from the data valid strobe and records what it sees
`timescale 1ns/1ns
module pdt_panel_model (
    input  wire logic         link_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         supply_in,
    input  wire logic         strobe_in,
    input  wire logic         map_in,
    input  wire logic         pattern_in,
    input  wire logic [119:0] pix_in,
    output int                frame_cnt_out,
    output int                frame_lines_out,
    output int                frame_gap_out,
    output int                last_hb_out,
    output int                line_err_out,
    output int                off_err_out,
    output logic [119:0]      pix_seen_out
);
    // ----------------------------------------
    // Framing
    // ----------------------------------------
    // Syncs are not wired in at all: lines and frames come from the strobe alone
    localparam int LINE_MAX = 680;
    logic prev_q;
    int   run_q;
    int   gap_q;
    int   lines_q;
    always @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prev_q <= 1'b0;
            run_q <= 0;
            gap_q <= 1_000_000;
            lines_q <= 0;
            frame_cnt_out <= 0;
            frame_lines_out <= 0;
            frame_gap_out <= 0;
            last_hb_out <= 0;
            line_err_out <= 0;
            off_err_out <= 0;
            pix_seen_out <= '0;
        end
        else
        begin
            prev_q <= strobe_in;
            // Unpowered panel: every line driven low, floating counts as an error too
            if ((strobe_in | map_in | pattern_in | (|pix_in)) !== 1'b0 && !supply_in)
                off_err_out <= off_err_out + 1;
            if (!supply_in)
                gap_q <= 1_000_000;
            else if (!strobe_in)
                gap_q <= gap_q + 1;
            else
                gap_q <= 0;
            if (strobe_in)
            begin
                run_q <= run_q + 1;
                // Rendered level is the code itself, so brightness rises with it
                pix_seen_out <= pix_in;
            end
            if (strobe_in && !prev_q && gap_q > LINE_MAX)
            begin
                frame_cnt_out <= frame_cnt_out + 1;
                frame_lines_out <= lines_q;
                frame_gap_out <= gap_q;
                lines_q <= 0;
            end
            else if (strobe_in && !prev_q)
                last_hb_out <= gap_q;
            if (!strobe_in && prev_q)
            begin
                run_q <= 0;
                lines_q <= lines_q + 1;
                if (run_q != 480)
                    line_err_out <= line_err_out + 1;
            end
        end
    end
endmodule : pdt_panel_model

// [tb/panel_de_video_timing_bench.sv]
// Self-checking bench for the panel video source controller
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t: %s", $time, msg); \
        end \
    end
module panel_de_video_timing_bench;
    localparam int unsigned SUP = 20;
    // Longer than one active line, so a line finished after signal-off sees supply
    localparam int unsigned OFF = 40;
    localparam int unsigned DIS = 50;
    localparam int unsigned LIT = 30;
    localparam logic [119:0] PIX = {10'h1fe, 10'h202, 10'h001, 30'h0,
                                    10'h3ff, 10'h3ff, 10'h3ff, 20'h0, 10'h3ff};
    logic ref_clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic power_req_in = 1'b0, low_rate_in = 1'b0, ssc_in = 1'b0, wide_colour_in = 1'b1;
    logic alt_bit_mapping_in = 1'b1, test_pattern_in = 1'b1;
    logic [pdt_pkg::CNT_W-1:0] line_blank_clocks_in = 12'h01e, frame_blank_lines_in = 12'h00a;
    logic [119:0] pix_in = PIX;
    logic pix_req_out, panel_logic_supply_out, backlight_on_out, alt_bit_mapping_out;
    logic internal_test_pattern_out, data_valid_strobe_out, hsync_out, vsync_out, ready_out;
    logic [119:0] pix_out, pix_seen;
    int frame_cnt, frame_lines, frame_gap, last_hb, line_err, off_err;
    int n_mismatch = 0;
    int n_checks = 0;
    initial
    begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    initial
    begin
        #2;
        forever #3 link_clk_in = ~link_clk_in;
    end
    pdt_source #(.SUP_TO_SIG_CYC(SUP), .SIG_TO_OFF_CYC(OFF), .OFF_TO_ON_CYC(DIS),
                 .SIG_TO_LIT_CYC(LIT)) pdt_source_i (
        .ref_clk_in, .rst_n_in, .link_clk_in, .power_req_in, .low_rate_in, .ssc_in,
        .wide_colour_in, .alt_bit_mapping_in, .test_pattern_in, .line_blank_clocks_in,
        .frame_blank_lines_in, .pix_in, .pix_req_out, .panel_logic_supply_out,
        .backlight_on_out, .alt_bit_mapping_out, .internal_test_pattern_out,
        .data_valid_strobe_out, .hsync_out, .vsync_out, .pix_out, .ready_out);
    pdt_panel_model pdt_panel_model_i (
        .link_clk_in, .rst_n_in, .supply_in(panel_logic_supply_out),
        .strobe_in(data_valid_strobe_out), .map_in(alt_bit_mapping_out),
        .pattern_in(internal_test_pattern_out), .pix_in(pix_out), .frame_cnt_out(frame_cnt),
        .frame_lines_out(frame_lines), .frame_gap_out(frame_gap), .last_hb_out(last_hb),
        .line_err_out(line_err), .off_err_out(off_err), .pix_seen_out(pix_seen));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic sel(input int w);
        case (w)
            0: return panel_logic_supply_out;
            1: return alt_bit_mapping_out;
            default: return backlight_on_out;
        endcase
    endfunction : sel
    // Counts ref edges until the chosen output reaches lvl; gives up after 1000
    task automatic wait_lvl(input int w, input logic lvl, output int n);
        n = 0;
        while (sel(w) !== lvl && n < 1000)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask : wait_lvl
    function automatic logic [119:0] m8(input logic [119:0] p);
        for (int i = 0; i < 12; i++)
            p[i*10 +: 2] = 2'h0;
        return p;
    endfunction : m8
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up(input int lo);
        int n;
        @(posedge ref_clk_in);
        power_req_in <= 1'b1;
        #1;
        wait_lvl(0, 1'b1, n);
        `CHK(n + 1 >= lo && n <= lo + 3, 1'b1, "supply on timing")
        wait_lvl(1, 1'b1, n);
        `CHK(n >= SUP && n < 1000, 1'b1, "signals on timing")
        wait_lvl(2, 1'b1, n);
        `CHK(n + 1 >= LIT && n < 1000, 1'b1, "backlight on timing")
        `CHK(ready_out, 1'b1, "ready")
        $display("power up done");
    endtask : t_power_up
    task automatic t_frame(input int hb, input int vb, input logic [119:0] px);
        int f0;
        int n;
        f0 = frame_cnt;
        n = 0;
        while (frame_cnt < f0 + 1 && n < 50000)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        `CHK(n < 50000, 1'b1, "frame never ended")
        `CHK(frame_lines, 1080, "active lines")
        `CHK(frame_gap, hb + vb * (480 + hb), "frame blank")
        `CHK(last_hb, hb, "line blank")
        `CHK(line_err, 0, "active clocks")
        `CHK(pix_seen, px, "pixel data")
        $display("frame done");
    endtask : t_frame
    task automatic t_map;
        int n;
        @(posedge ref_clk_in);
        alt_bit_mapping_in <= 1'b0;
        #1;
        wait_lvl(1, 1'b0, n);
        `CHK(n < 5, 1'b1, "mapping select")
        @(posedge ref_clk_in);
        alt_bit_mapping_in <= 1'b1;
        #1;
        wait_lvl(1, 1'b1, n);
        `CHK(n < 5, 1'b1, "mapping select")
        $display("mapping done");
    endtask : t_map
    task automatic t_power_down;
        int n;
        @(posedge ref_clk_in);
        power_req_in <= 1'b0;
        #1;
        wait_lvl(2, 1'b0, n);
        `CHK(n <= 3, 1'b1, "backlight off")
        wait_lvl(1, 1'b0, n);
        `CHK(n <= 3, 1'b1, "signals off")
        `CHK(internal_test_pattern_out, 1'b0, "pattern off")
        wait_lvl(0, 1'b0, n);
        `CHK(n + 1 >= OFF && n < 1000, 1'b1, "supply off timing")
        `CHK(data_valid_strobe_out, 1'b0, "strobe low")
        `CHK(pix_out, 120'h0, "data low")
        $display("power down done");
    endtask : t_power_down
    initial
    begin
        #(120_000 * 100);
        n_mismatch++;
        $display("mismatch at %0t: watchdog", $time);
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_power_up(0);
        `CHK(internal_test_pattern_out, 1'b1, "pattern on")
        t_frame(pdt_pkg::LINE_BLANK_MIN, pdt_pkg::FRAME_BLANK_MIN, PIX);
        t_power_down();
        @(posedge ref_clk_in);
        low_rate_in <= 1'b1;
        ssc_in <= 1'b1;
        wide_colour_in <= 1'b0;
        test_pattern_in <= 1'b0;
        line_blank_clocks_in <= 12'h028;
        frame_blank_lines_in <= 12'h190;
        t_power_up(DIS);
        t_map();
        t_frame(pdt_pkg::LINE_BLANK_MIN + pdt_pkg::SSC_EXTRA_CLOCKS,
                pdt_pkg::FRAME_BLANK_LO_MAX, m8(PIX));
        t_power_down();
        `CHK(off_err, 0, "unpowered lines")
        stop_test();
    end
endmodule : panel_de_video_timing_bench
